/* File: rccr_top.sv */
// AXI4-Lite register bank with calibration timer and wake cycle sequencer
`timescale 1ns/10ps
`include "rccr_regs.svh"

module rccr_top #(
  parameter int unsigned UNIT_SHORT_CYCLES = `RCCR_UNIT_SHORT_CYC,
  parameter int unsigned UNIT_MID_CYCLES = `RCCR_UNIT_MID_CYC,
  parameter int unsigned UNIT_LONG_CYCLES = `RCCR_UNIT_LONG_CYC,
  parameter int unsigned RC_CAL_CYCLES = `RCCR_RC_CAL_CYC,
  parameter logic [7:0] VERSION_CODE = 8'h5A // Arbitrary value
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Radio core settings
  input wire logic [7:0] symbol_rate_high,
  output rccr_pkg::rccr_radio_s radio_cfg,
  output logic rc_cal_running,
  // Wake cycle
  input wire logic [2:0] op_state,
  input wire logic wake_cycle_enable,
  input wire logic signal_level_limit,
  input wire logic sync_match,
  input wire logic frame_complete_flag,
  input wire logic rx_timeout,
  output logic wake_rx_on,
  output logic wake_stopped,
  output logic wake_mode_enter,
  output logic fifo_discard
);

  localparam int CAL_BOUND = RC_CAL_CYCLES + 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------

  // Word aligned and inside the bank
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a[1:0] == 2'h0) && (a[7:2] >= `RCCR_IDX_RATE_LOW) &&
               (a[7:2] <= `RCCR_IDX_STATUS);
  endfunction

  // Unit length in cycles; reserved code 00 falls back to the short unit
  function automatic logic [23:0] unit_cycles(input logic [1:0] code);
    case (code)
      2'h2: unit_cycles = 24'(UNIT_MID_CYCLES);
      2'h3: unit_cycles = 24'(UNIT_LONG_CYCLES);
      default: unit_cycles = 24'(UNIT_SHORT_CYCLES);
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [7:0] rate_low_q;
  logic [5:0] dev_high_q;
  logic [7:0] dev_low_q;
  logic [7:0] car_high_q;
  logic [7:0] car_mid_q;
  logic [7:0] car_low_q;
  logic low_index_q;
  rccr_pkg::rccr_wake_cfg_s wake_cfg_q;
  logic [7:0] idle_cnt_q;
  logic [7:0] rx_cnt_q;
  logic cal_busy_q;
  logic [15:0] cal_cnt_q;

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  logic aw_held_q;
  logic [7:0] aw_addr_q;
  logic w_held_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // Address and data are taken in either order; one write in flight
  wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire wr_hit = addr_hit(aw_addr_q);
  wire wr_en = wr_fire && wr_hit && wlane_q;
  wire [5:0] wr_idx = aw_addr_q[7:2];
  assign awready = !aw_held_q && !bvalid_q;
  assign wready = !w_held_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // Channel holding registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with a decode error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------

  // Only writable fields are stored; fixed bits are rebuilt on read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_low_q <= `RCCR_RST_RATE_LOW;
      dev_high_q <= `RCCR_RST_DEV_HIGH;
      dev_low_q <= `RCCR_RST_DEV_LOW;
      car_high_q <= `RCCR_RST_CAR_HIGH;
      car_mid_q <= `RCCR_RST_CAR_MID;
      car_low_q <= `RCCR_RST_CAR_LOW;
      low_index_q <= 1'b0;
      wake_cfg_q <= rccr_pkg::rccr_wake_cfg_s'(`RCCR_RST_WAKE_CFG);
      idle_cnt_q <= `RCCR_RST_IDLE_CNT;
      rx_cnt_q <= `RCCR_RST_RX_CNT;
    end else if (wr_en) begin
      case (wr_idx)
        `RCCR_IDX_RATE_LOW: rate_low_q <= wbyte_q;
        `RCCR_IDX_DEV_HIGH: dev_high_q <= wbyte_q[5:0];
        `RCCR_IDX_DEV_LOW: dev_low_q <= wbyte_q;
        `RCCR_IDX_CAR_HIGH: car_high_q <= wbyte_q;
        `RCCR_IDX_CAR_MID: car_mid_q <= wbyte_q;
        `RCCR_IDX_CAR_LOW: car_low_q <= wbyte_q;
        `RCCR_IDX_CORR: low_index_q <= wbyte_q[`RCCR_BIT_LOW_INDEX];
        `RCCR_IDX_WAKE_CFG: begin
          wake_cfg_q <= rccr_pkg::rccr_wake_cfg_s'({wbyte_q[7:1], 1'b0});
        end
        `RCCR_IDX_IDLE_CNT: idle_cnt_q <= wbyte_q;
        `RCCR_IDX_RX_CNT: rx_cnt_q <= wbyte_q;
        default: ;
      endcase
    end
  end

  // Settings as seen by the radio core, one driver in struct field order
  assign radio_cfg = {symbol_rate_high, rate_low_q,
                      dev_high_q, dev_low_q,
                      car_high_q, car_mid_q, car_low_q,
                      low_index_q};

  // ----------------------------------------------------------------------
  // RC oscillator calibration
  // ----------------------------------------------------------------------

  // The trigger is a write strobe only, it is never stored
  wire cal_start = wr_en && (wr_idx == `RCCR_IDX_RC_CAL) &&
                   wbyte_q[`RCCR_BIT_CAL_TRIGGER];
  wire rc_cal_finished = !cal_busy_q;
  assign rc_cal_running = cal_busy_q;

  // A new trigger during a run restarts it rather than being dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_busy_q <= 1'b0;
      cal_cnt_q <= 16'h0000;
    end else if (cal_start) begin
      cal_busy_q <= 1'b1;
      cal_cnt_q <= 16'h0000;
    end else if (cal_busy_q) begin
      if (cal_cnt_q == 16'(RC_CAL_CYCLES - 1)) begin
        cal_busy_q <= 1'b0;
      end
      cal_cnt_q <= cal_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Wake cycle sequencer
  // ----------------------------------------------------------------------
  rccr_pkg::rccr_wake_e wake_st_q;
  rccr_pkg::rccr_wake_e wake_st_d;
  logic [23:0] unit_cnt_q;
  logic [7:0] coef_cnt_q;
  logic discard_pend_q;
  logic stop_rx_q;

  // Phase timer: unit prescaler followed by a coefficient counter
  wire in_idle = (wake_st_q == rccr_pkg::WAKE_IDLE);
  wire [23:0] unit_len = in_idle ?
                         unit_cycles(wake_cfg_q.idle_time_unit) :
                         unit_cycles(wake_cfg_q.rx_time_unit);
  wire [7:0] coef_lim = in_idle ? idle_cnt_q : rx_cnt_q;
  wire unit_tick = (unit_cnt_q >= unit_len - 24'h000001);
  wire phase_done = unit_tick &&
                    ({1'b0, coef_cnt_q} + 9'h001 >= {1'b0, coef_lim});
  wire accept = signal_level_limit &&
                (!wake_cfg_q.wake_accept_rule || sync_match);
  wire frame_end = frame_complete_flag || rx_timeout;
  wire [1:0] action = wake_cfg_q.post_accept_action;
  wire st_change = (wake_st_d != wake_st_q);

  // Next state; dropping the enable abandons the cycle from any state
  always_comb begin
    wake_st_d = wake_st_q;
    case (wake_st_q)
      rccr_pkg::WAKE_OFF: begin
        if (wake_cycle_enable) wake_st_d = rccr_pkg::WAKE_IDLE;
      end
      rccr_pkg::WAKE_IDLE: begin
        if (!wake_cycle_enable) wake_st_d = rccr_pkg::WAKE_OFF;
        else if (phase_done) wake_st_d = rccr_pkg::WAKE_RX;
      end
      rccr_pkg::WAKE_RX: begin
        if (!wake_cycle_enable) begin
          wake_st_d = rccr_pkg::WAKE_OFF;
        end else if (accept) begin
          // Reserved action 11 is handled like 00
          if (action == 2'h1 || action == 2'h2) begin
            wake_st_d = rccr_pkg::WAKE_HOLD;
          end else begin
            wake_st_d = rccr_pkg::WAKE_STOP;
          end
        end else if (phase_done) begin
          wake_st_d = rccr_pkg::WAKE_IDLE;
        end
      end
      rccr_pkg::WAKE_HOLD: begin
        if (!wake_cycle_enable) begin
          wake_st_d = rccr_pkg::WAKE_OFF;
        end else if (frame_end) begin
          wake_st_d = (action == 2'h2) ? rccr_pkg::WAKE_IDLE
                                       : rccr_pkg::WAKE_STOP;
        end
      end
      rccr_pkg::WAKE_STOP: begin
        if (!wake_cycle_enable) wake_st_d = rccr_pkg::WAKE_OFF;
      end
      default: wake_st_d = rccr_pkg::WAKE_OFF;
    endcase
  end

  // State and phase counters; counters restart on every state change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_st_q <= rccr_pkg::WAKE_OFF;
      unit_cnt_q <= 24'h000000;
      coef_cnt_q <= 8'h00;
    end else begin
      wake_st_q <= wake_st_d;
      if (st_change) begin
        unit_cnt_q <= 24'h000000;
        coef_cnt_q <= 8'h00;
      end else if (unit_tick) begin
        unit_cnt_q <= 24'h000000;
        coef_cnt_q <= coef_cnt_q + 8'h01;
      end else begin
        unit_cnt_q <= unit_cnt_q + 24'h000001;
      end
    end
  end

  // Discard is owed after a resumed cycle and paid at the next wake-up
  wire resume_idle = (wake_st_q == rccr_pkg::WAKE_HOLD) &&
                     (wake_st_d == rccr_pkg::WAKE_IDLE);
  wire rx_wakeup = in_idle && (wake_st_d == rccr_pkg::WAKE_RX);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      discard_pend_q <= 1'b0;
      stop_rx_q <= 1'b0;
    end else begin
      if (resume_idle) begin
        discard_pend_q <= 1'b1;
      end else if (rx_wakeup || wake_st_q == rccr_pkg::WAKE_OFF) begin
        discard_pend_q <= 1'b0;
      end
      if (wake_st_q != rccr_pkg::WAKE_STOP) begin
        stop_rx_q <= (wake_st_q == rccr_pkg::WAKE_RX);
      end
    end
  end

  // Sequencer outputs to the radio core
  assign fifo_discard = rx_wakeup && discard_pend_q;
  assign wake_mode_enter = (wake_st_q == rccr_pkg::WAKE_HOLD) &&
                           (wake_st_d == rccr_pkg::WAKE_STOP);
  assign wake_stopped = (wake_st_q == rccr_pkg::WAKE_STOP);
  assign wake_rx_on = (wake_st_q == rccr_pkg::WAKE_RX) ||
                      (wake_st_q == rccr_pkg::WAKE_HOLD) ||
                      (wake_stopped && stop_rx_q);

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  logic rvalid_q;
  logic [7:0] rbyte_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_byte;
  wire rd_hit = addr_hit(araddr);
  wire ar_fire = arvalid && arready;
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = {24'h000000, rbyte_q};
  assign rresp = rresp_q;

  // Read mux; fixed bits are constants so writes cannot disturb them
  always_comb begin
    case (araddr[7:2])
      `RCCR_IDX_RATE_LOW: rd_byte = rate_low_q;
      `RCCR_IDX_DEV_HIGH: rd_byte = {2'h0, dev_high_q};
      `RCCR_IDX_DEV_LOW: rd_byte = dev_low_q;
      `RCCR_IDX_CAR_HIGH: rd_byte = car_high_q;
      `RCCR_IDX_CAR_MID: rd_byte = car_mid_q;
      `RCCR_IDX_CAR_LOW: rd_byte = car_low_q;
      `RCCR_IDX_RC_CAL: begin
        rd_byte = {1'b0, rc_cal_finished, `RCCR_RST_CAL_SPARE};
      end
      `RCCR_IDX_CORR: rd_byte = {2'h0, low_index_q, 5'h00};
      `RCCR_IDX_RSVD: rd_byte = `RCCR_RST_RSVD;
      `RCCR_IDX_WAKE_CFG: rd_byte = wake_cfg_q;
      `RCCR_IDX_IDLE_CNT: rd_byte = idle_cnt_q;
      `RCCR_IDX_RX_CNT: rd_byte = rx_cnt_q;
      `RCCR_IDX_VERSION: rd_byte = VERSION_CODE;
      `RCCR_IDX_STATUS: begin
        rd_byte = {3'h0, wake_stopped, wake_rx_on, op_state};
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data is registered; one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rbyte_q <= 8'h00;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rbyte_q <= rd_hit ? rd_byte : 8'h00;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_defaults: assert property ($past(!aresetn) |->
    rate_low_q == `RCCR_RST_RATE_LOW && car_high_q == `RCCR_RST_CAR_HIGH &&
    rc_cal_finished)
    else $error("Defaults not loaded after reset");

  a_rate_low_write: assert property (wr_en &&
    wr_idx == `RCCR_IDX_RATE_LOW |=>
    radio_cfg.symbol_rate_divisor[7:0] == $past(wbyte_q))
    else $error("Divisor low byte not updated");

  a_carrier_order: assert property (wr_en &&
    wr_idx == `RCCR_IDX_CAR_HIGH |=>
    radio_cfg.carrier_word[23:16] == $past(wbyte_q))
    else $error("Carrier high byte misplaced");

  a_cal_busy_start: assert property (cal_start |=>
    !rc_cal_finished [*2])
    else $error("Calibration did not start");

  a_cal_ends: assert property ($rose(cal_busy_q) |->
    ##[1:CAL_BOUND] !cal_busy_q)
    else $error("Calibration did not finish in time");

  a_trigger_reads_zero: assert property (ar_fire &&
    araddr[7:2] == `RCCR_IDX_RC_CAL |=> !rdata[`RCCR_BIT_CAL_TRIGGER])
    else $error("Calibration trigger read as one");

  a_accept_leaves_rx: assert property (wake_st_q == rccr_pkg::WAKE_RX &&
    wake_cycle_enable && signal_level_limit &&
    (sync_match || !wake_cfg_q.wake_accept_rule) |=>
    wake_st_q != rccr_pkg::WAKE_RX)
    else $error("Accepted frame kept wake cycle in receive");

  a_idle_length: assert property (in_idle ##1
    wake_st_q == rccr_pkg::WAKE_RX |->
    $past(coef_cnt_q) + 8'h01 >= $past(idle_cnt_q) && $past(unit_tick))
    else $error("Idle phase ended early");

  a_resume_discard: assert property (resume_idle |=>
    in_idle && discard_pend_q)
    else $error("Resume did not schedule a discard");

  a_version_read: assert property (ar_fire &&
    araddr == {`RCCR_IDX_VERSION, 2'h0} |=> rdata[7:0] == VERSION_CODE)
    else $error("Version byte wrong");

endmodule

/* File: rccr_regs.svh */
// Register map, reset values and timing constants of the radio config bank
`ifndef RCCR_REGS_SVH
`define RCCR_REGS_SVH
// ----------------------------------------------------------------------
// Contract
// - Symbol rate divisor is high byte input plus low byte register.
// - Deviation word is a 6-bit upper field and an 8-bit lower byte.
// - Carrier word is three byte registers, most significant first.
// - Writing one to the calibration trigger starts it; trigger reads zero.
// - Calibration finished reads zero while running, one when done, one at reset.
// - Low index select picks improved or standard frequency correction.
// - Idle unit code 01 is 64 us, 10 is 4.1 ms, 11 is 262 ms.
// - Receive unit code at bits 5-4 uses the same encoding.
// - Accept on signal level alone, or level plus sync match.
// - Action 00 stays in receive and stops the wake cycle.
// - Action 01 waits for frame end, enters operating state, stops cycle.
// - Action 10 waits for frame end, resumes idle, discards at next wake.
// - Idle phase lasts idle count times idle unit.
// - Receive phase lasts receive count times receive unit.
// - Version byte is read only: full revision high, mask revision low.
// - Operating state field encodes five states and reads the current one.
// ----------------------------------------------------------------------

// Register indices; byte address is four times the index
`define RCCR_IDX_RATE_LOW 6'h04
`define RCCR_IDX_DEV_HIGH 6'h05
`define RCCR_IDX_DEV_LOW 6'h06
`define RCCR_IDX_CAR_HIGH 6'h07
`define RCCR_IDX_CAR_MID 6'h08
`define RCCR_IDX_CAR_LOW 6'h09
`define RCCR_IDX_RC_CAL 6'h0A
`define RCCR_IDX_CORR 6'h0B
`define RCCR_IDX_RSVD 6'h0C
`define RCCR_IDX_WAKE_CFG 6'h0D
`define RCCR_IDX_IDLE_CNT 6'h0E
`define RCCR_IDX_RX_CNT 6'h0F
`define RCCR_IDX_VERSION 6'h10
`define RCCR_IDX_STATUS 6'h11

// Field positions
`define RCCR_BIT_CAL_TRIGGER 7
`define RCCR_BIT_CAL_DONE 6
`define RCCR_BIT_LOW_INDEX 5

// Reset values
`define RCCR_RST_RATE_LOW 8'h0B
`define RCCR_RST_DEV_HIGH 6'h00
`define RCCR_RST_DEV_LOW 8'h52
`define RCCR_RST_CAR_HIGH 8'hE4
`define RCCR_RST_CAR_MID 8'hC0
`define RCCR_RST_CAR_LOW 8'h00
`define RCCR_RST_CAL_SPARE 6'h01
`define RCCR_RST_RSVD 8'h02
`define RCCR_RST_WAKE_CFG 8'h92
`define RCCR_RST_IDLE_CNT 8'hF5
`define RCCR_RST_RX_CNT 8'h20

// Timing: unit times in ns and cycle counts at a 20 ns clock
`define RCCR_CLK_PERIOD_NS 20
`define RCCR_UNIT_SHORT_NS 64000
`define RCCR_UNIT_MID_NS 4100000
`define RCCR_UNIT_LONG_NS 262000000
`define RCCR_UNIT_SHORT_CYC (`RCCR_UNIT_SHORT_NS / `RCCR_CLK_PERIOD_NS)
`define RCCR_UNIT_MID_CYC (`RCCR_UNIT_MID_NS / `RCCR_CLK_PERIOD_NS)
`define RCCR_UNIT_LONG_CYC (`RCCR_UNIT_LONG_NS / `RCCR_CLK_PERIOD_NS)
`define RCCR_RC_CAL_CYC 64

`endif

/* File: rccr_pkg.sv */
// Types shared by the radio config bank
package rccr_pkg;

  // Wake cycle sequencer states
  typedef enum logic [2:0] {
    WAKE_OFF, WAKE_IDLE, WAKE_RX, WAKE_HOLD, WAKE_STOP
  } rccr_wake_e;

  // Wake cycle configuration byte
  typedef struct packed {
    logic [1:0] idle_time_unit;
    logic [1:0] rx_time_unit;
    logic wake_accept_rule;
    logic [1:0] post_accept_action;
    logic spare;
  } rccr_wake_cfg_s;

  // Settings handed to the radio core
  typedef struct packed {
    logic [15:0] symbol_rate_divisor;
    logic [13:0] deviation_word;
    logic [23:0] carrier_word;
    logic low_index_correction_select;
  } rccr_radio_s;

endpackage

/* File: rccr_tb.sv */
// Self-checking bench for the radio config register bank
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic aclk = 1'h0, aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic en = 1'h0, lvl = 1'h0, sync = 1'h0, frame = 1'h0, tmo = 1'h0;
  logic [7:0] srh = 8'h3C;
  logic [3:0] stb = 4'hF;
  logic [2:0] op = 3'h1;
  logic awready, wready, bvalid, arready, rvalid, cal_run;
  logic rx_on, stopped, mode_pulse, discard;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  rccr_pkg::rccr_radio_s cfg;
  int fails = 0, tests_run = 0, disc_cnt = 0, mode_cnt = 0, n;

  // Short unit and calibration counts keep the run brief
  localparam int unsigned SHORT_CYC = 4;
  localparam int unsigned MID_CYC = 8;
  localparam int unsigned LONG_CYC = 16;
  localparam int unsigned CAL_CYC = 8;
  localparam logic [7:0] VERSION = 8'hA3;
  rccr_top #(.UNIT_SHORT_CYCLES(SHORT_CYC), .UNIT_MID_CYCLES(MID_CYC),
    .UNIT_LONG_CYCLES(LONG_CYC), .RC_CAL_CYCLES(CAL_CYC),
    .VERSION_CODE(VERSION)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(stb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .symbol_rate_high(srh), .radio_cfg(cfg),
    .rc_cal_running(cal_run), .op_state(op), .wake_cycle_enable(en),
    .signal_level_limit(lvl), .sync_match(sync),
    .frame_complete_flag(frame), .rx_timeout(tmo), .wake_rx_on(rx_on),
    .wake_stopped(stopped), .wake_mode_enter(mode_pulse),
    .fifo_discard(discard));

  initial begin
    forever #10 aclk = ~aclk;
  end

  // One-cycle pulses are counted here so no task can miss them
  always @(posedge aclk) begin
    if (discard === 1'h1) disc_cnt <= disc_cnt + 1;
    if (mode_pulse === 1'h1) mode_cnt <= mode_cnt + 1;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [5:0] i, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic w(input logic [5:0] i, input logic [7:0] d);
    logic [1:0] r;
    wr(i, d, r);
    chk({30'h0, r}, 32'h0);
  endtask

  task automatic rc(input logic [5:0] i, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, 32'h0);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask

  // Cycles the receiver flag keeps level v, sampled after each edge
  task automatic cnt(input logic v, output int k);
    k = 0;
    while (rx_on === v && k < 300) begin
      @(posedge aclk);
      #1;
      k++;
    end
  endtask

  task automatic set_en(input logic v);
    @(posedge aclk);
    en <= v;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [7:0] e [13] = '{8'h0B, 8'h00, 8'h52, 8'hE4, 8'hC0, 8'h00,
      8'h41, 8'h00, 8'h02, 8'h92, 8'hF5, 8'h20, 8'hA3};
    for (int i = 0; i < 13; i++) rc(6'(4 + i), e[i]);
    chk({16'h0, cfg.symbol_rate_divisor}, 32'h3C0B);
    chk({18'h0, cfg.deviation_word}, 32'h52);
    chk({8'h0, cfg.carrier_word}, 32'hE4C000);
    $display("reset test done");
  endtask

  task automatic t_access;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] e [13] = '{8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'h41, 8'h20, 8'h02, 8'hFE, 8'hFF, 8'hFF, 8'hA3};
    for (int i = 0; i < 13; i++) w(6'(4 + i), (i == 6) ? 8'h7F : 8'hFF);
    for (int i = 0; i < 13; i++) rc(6'(4 + i), e[i]);
    chk({31'h0, cfg.low_index_correction_select}, 32'h1);
    w(6'h04, 8'h9D);
    w(6'h05, 8'h2A);
    w(6'h06, 8'h5C);
    w(6'h07, 8'h12);
    w(6'h08, 8'h34);
    w(6'h09, 8'h56);
    w(6'h0B, 8'h00);
    chk({16'h0, cfg.symbol_rate_divisor}, 32'h3C9D);
    @(posedge aclk);
    srh <= 8'hC3;
    stb <= 4'hE;
    w(6'h04, 8'h11);
    rc(6'h04, 8'h9D);
    chk({16'h0, cfg.symbol_rate_divisor}, 32'hC39D);
    @(posedge aclk);
    stb <= 4'hF;
    chk({18'h0, cfg.deviation_word}, 32'h2A5C);
    chk({8'h0, cfg.carrier_word}, 32'h123456);
    chk({31'h0, cfg.low_index_correction_select}, 32'h0);
    rd(6'h12, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h3);
    wr(6'h20, 8'h11, r);
    chk({30'h0, r}, 32'h3);
    $display("access test done");
  endtask

  task automatic t_cal;
    w(6'h0A, 8'h80);
    rc(6'h0A, 8'h01);
    cyc(1);
    chk({31'h0, cal_run}, 32'h1);
    cyc(10);
    rc(6'h0A, 8'h41);
    chk({31'h0, cal_run}, 32'h0);
    $display("calibration test done");
  endtask

  // Unit codes 01, 10 and 11 on both phases: idle is 3 units, receive is 1 unit
  task automatic t_units;
    int u, v;
    for (int c = 1; c < 4; c++) begin
      u = (c == 1) ? SHORT_CYC : (c == 2) ? MID_CYC : LONG_CYC;
      v = (c == 3) ? SHORT_CYC : (c == 2) ? MID_CYC : LONG_CYC;
      set_en(1'h0);
      w(6'h0D, {2'(c), 2'(4 - c), 4'h4});
      w(6'h0E, 8'h03);
      w(6'h0F, 8'h01);
      set_en(1'h1);
      cnt(1'h0, n);
      cnt(1'h1, n);
      chk(n, v);
      cnt(1'h0, n);
      chk(n, 3 * u);
    end
    chk(disc_cnt, 0);
    $display("unit test done");
  endtask

  task automatic t_resume;
    set_en(1'h0);
    w(6'h0D, 8'h54);
    set_en(1'h1);
    cnt(1'h0, n);
    @(posedge aclk);
    lvl <= 1'h1;
    cyc(20);
    chk({31'h0, rx_on}, 32'h1);
    @(posedge aclk);
    lvl <= 1'h0;
    frame <= 1'h1;
    @(posedge aclk);
    frame <= 1'h0;
    cyc(2);
    chk({31'h0, rx_on}, 32'h0);
    cnt(1'h0, n);
    cyc(2);
    chk(disc_cnt, 1);
    $display("resume test done");
  endtask

  task automatic t_rule;
    set_en(1'h0);
    lvl <= 1'h1;
    w(6'h0D, 8'h58);
    set_en(1'h1);
    cnt(1'h0, n);
    cnt(1'h1, n);
    chk(n, SHORT_CYC);
    @(posedge aclk);
    sync <= 1'h1;
    cnt(1'h0, n);
    cyc(3);
    chk({30'h0, stopped, rx_on}, 32'h3);
    rc(6'h11, 8'h19);
    set_en(1'h0);
    lvl <= 1'h0;
    sync <= 1'h0;
    cyc(3);
    chk({31'h0, stopped}, 32'h0);
    $display("accept rule test done");
  endtask

  task automatic t_end01;
    int m0;
    w(6'h0D, 8'h52);
    m0 = mode_cnt;
    set_en(1'h1);
    cnt(1'h0, n);
    @(posedge aclk);
    lvl <= 1'h1;
    cyc(3);
    @(posedge aclk);
    lvl <= 1'h0;
    tmo <= 1'h1;
    @(posedge aclk);
    tmo <= 1'h0;
    cyc(3);
    chk(mode_cnt - m0, 1);
    chk({30'h0, stopped, rx_on}, 32'h2);
    @(posedge aclk);
    op <= 3'h4;
    rc(6'h11, 8'h14);
    set_en(1'h0);
    op <= 3'h1;
    $display("mode entry test done");
  endtask

  // A reset in mid-run brings written registers back to defaults
  task automatic t_rst2;
    @(posedge aclk);
    aresetn <= 1'h0;
    cyc(2);
    @(posedge aclk);
    aresetn <= 1'h1;
    rc(6'h04, 8'h0B);
    rc(6'h0D, 8'h92);
    chk({8'h0, cfg.carrier_word}, 32'hE4C000);
    $display("second reset test done");
  endtask

  // ----------------------------------------
  // Sequence, verdict and watchdog
  // ----------------------------------------
  task automatic stop_test;
    $display("Counts: %0d compares, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_access();
    t_cal();
    t_units();
    t_resume();
    t_rule();
    t_end01();
    t_rst2();
    stop_test();
  end

  // About thirty times the expected run length
  initial begin
    #400000;
    fails++;
    stop_test();
  end
endmodule
